// ==== rtl/lt_cfg.svh ====
// register offsets, field positions, reset values and counts of the lifetime timer
`ifndef LT_CFG_SVH
`define LT_CFG_SVH
// ==========================================
// register byte addresses
`define LT_OFS_RELOAD 32'hFFFF0300
`define LT_OFS_CNT_LO 32'hFFFF0304
`define LT_OFS_CNT_HI 32'hFFFF0308
`define LT_OFS_CONFIG 32'hFFFF030C
`define LT_OFS_IRQACK 32'hFFFF0310
`define LT_OFS_SNAP 32'hFFFF0314
// ==========================================
// lifetime_config field positions
`define LT_CFG_CAP_EN 17
`define LT_CFG_EVT_HI 16
`define LT_CFG_EVT_LO 12
`define LT_CFG_SRC_HI 10
`define LT_CFG_SRC_LO 9
`define LT_CFG_UP 8
`define LT_CFG_RUN 7
`define LT_CFG_PERIODIC 6
`define LT_CFG_WIDE 4
`define LT_CFG_PRE_HI 3
`define LT_CFG_PRE_LO 0
// implemented bits of lifetime_config
`define LT_CFG_WMASK 32'h0003F7DF
// ==========================================
// reset values
`define LT_RST_RELOAD 16'h0000
`define LT_RST_CONFIG 32'h00000000
`define LT_RST_CNT 48'h000000000000
`define LT_RST_SNAP 16'h0000
// ==========================================
// clock source and prescaler codes
`define LT_SRC_CORE 2'h0
`define LT_SRC_LPOSC 2'h1
`define LT_SRC_XTAL 2'h2
`define LT_SRC_PRECOSC 2'h3
`define LT_PRE_DIV1 4'h0
`define LT_PRE_DIV16 4'h4
`define LT_PRE_DIV256 4'h8
`define LT_PRE_DIV32768 4'hF
// last prescaler count of each ratio
`define LT_PRE_LAST16 15'h000F
`define LT_PRE_LAST256 15'h00FF
`define LT_PRE_LAST32768 15'h7FFF
// highest valid event number
`define LT_EVT_MAX 5'h11
`define LT_NUM_EVT 18
`endif

// ==== rtl/lt_pkg.sv ====
// types shared by the lifetime timer and its bench
package lt_pkg;
	// apb request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} lt_apb_req_t;
	// apb answer from the slave
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} lt_apb_rsp_t;
endpackage

// ==== rtl/lt_timer.sv ====
// lifetime counter with prescaler, capture and interrupt, on an apb slave
//
// Notes on behaviour
// - wide mode counts upward only, from zero, over 48 bits
// - config bit 8 picks up or down in 16-bit mode, down by default
// - reload register value is loaded into the 16-bit counter
// - in periodic mode an overflow reloads the count from the reload register
// - each rising edge of the chosen event copies the count; counting continues
// - snapshot is 16-bit read-only and captures only in 16-bit mode
// - config bit 17 enables event capture
// - config bits 16 to 12 give the event number, 0 to 17 valid
// - config bits 10 to 9 select core clock or one of three 32 kHz sources
// - config bit 7 runs or stops the counter, stopped after reset
// - config bit 6 picks periodic or free-running, free-running by default
// - config bit 4 picks 16-bit (default) or 48-bit width
// - config bits 3 to 0 set prescaler: 1, 16, 256 or 32768
// - count readback read-only: low half always, high word in wide mode
// - any write to the acknowledge register clears the interrupt, 16-bit mode only
// - interrupt in 16-bit mode on the tick that leaves zero counting down or full scale counting up
// - periodic mode restarts from the reload value at each interrupt
// - free-running mode wraps around with no reload
// - control and reload pass two stages clocked by the timer clock
`timescale 1ns/1ns
`include "lt_cfg.svh"

module lt_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire lt_pkg::lt_apb_req_t apb_req,
	output lt_pkg::lt_apb_rsp_t apb_rsp,
	input wire logic lposc_clk,
	input wire logic xtal_clk,
	input wire logic precosc_clk,
	input wire logic [`LT_NUM_EVT-1:0] irq_events,
	output logic irq_out
);
	import lt_pkg::*;

	// ==========================================
	// apb decode
	logic setup_w;
	logic wr_w;
	logic hit_w;
	logic [31:0] rd_w;
	logic [31:0] prdata_r;
	logic err_r;
	logic [15:0] reload_r;
	logic [31:0] config_r;
	logic [47:0] cnt_r;
	logic [15:0] snap_r;
	logic irq_r;

	assign setup_w = apb_req.psel & ~apb_req.penable;
	assign wr_w = apb_req.psel & apb_req.penable & apb_req.pwrite;

	// read mux; write-only and reserved bits read as zero
	always_comb begin
		hit_w = 1'b1;
		rd_w = 32'h00000000;
		unique case (apb_req.paddr)
			`LT_OFS_RELOAD: rd_w = {16'h0000, reload_r};
			`LT_OFS_CNT_LO: rd_w = {16'h0000, cnt_r[15:0]};
			`LT_OFS_CNT_HI: rd_w = cnt_r[47:16];
			`LT_OFS_CONFIG: rd_w = config_r;
			`LT_OFS_IRQACK: rd_w = 32'h00000000;
			`LT_OFS_SNAP: rd_w = {16'h0000, snap_r};
			default: hit_w = 1'b0;
		endcase
	end

	// read data and error are caught in the setup cycle, so they come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
			err_r <= 1'b0;
		end else if (setup_w) begin
			prdata_r <= apb_req.pwrite ? 32'h00000000 : rd_w;
			err_r <= ~hit_w;
		end
	end

	// zero wait states; unmapped addresses answer with pslverr
	assign apb_rsp.prdata = prdata_r;
	assign apb_rsp.pready = apb_req.psel & apb_req.penable;
	assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & err_r;

	// ==========================================
	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_r <= `LT_RST_RELOAD;
		end else if (wr_w && apb_req.paddr == `LT_OFS_RELOAD) begin
			reload_r <= apb_req.pwdata[15:0];
		end
	end

	// reserved bits never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_r <= `LT_RST_CONFIG;
		end else if (wr_w && apb_req.paddr == `LT_OFS_CONFIG) begin
			config_r <= apb_req.pwdata & `LT_CFG_WMASK;
		end
	end

	// ==========================================
	// clock source selection
	logic [2:0] pin_s1_r;
	logic [2:0] pin_s2_r;
	logic [2:0] pin_d_r;
	logic src_edge_w;

	// external sources pass two flops before anything reads them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r <= 3'h0;
			pin_s2_r <= 3'h0;
			pin_d_r <= 3'h0;
		end else begin
			pin_s1_r <= {precosc_clk, xtal_clk, lposc_clk};
			pin_s2_r <= pin_s1_r;
			pin_d_r <= pin_s2_r;
		end
	end

	// one timer-clock period per rising edge of the chosen source
	always_comb begin
		unique case (config_r[`LT_CFG_SRC_HI:`LT_CFG_SRC_LO])
			`LT_SRC_CORE: src_edge_w = 1'b1;
			`LT_SRC_LPOSC: src_edge_w = pin_s2_r[0] & ~pin_d_r[0];
			`LT_SRC_XTAL: src_edge_w = pin_s2_r[1] & ~pin_d_r[1];
			`LT_SRC_PRECOSC: src_edge_w = pin_s2_r[2] & ~pin_d_r[2];
		endcase
	end

	// ==========================================
	// two-stage transfer into the timer domain
	logic [31:0] ctl_s1_r;
	logic [31:0] ctl_s2_r;
	logic [15:0] ld_s1_r;
	logic [15:0] ld_s2_r;

	// stages advance on timer-clock periods, so changes land two periods later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_s1_r <= `LT_RST_CONFIG;
			ctl_s2_r <= `LT_RST_CONFIG;
			ld_s1_r <= `LT_RST_RELOAD;
			ld_s2_r <= `LT_RST_RELOAD;
		end else if (src_edge_w) begin
			ctl_s1_r <= config_r;
			ctl_s2_r <= ctl_s1_r;
			ld_s1_r <= reload_r;
			ld_s2_r <= ld_s1_r;
		end
	end

	logic run_w;
	logic wide_w;
	logic up_w;
	logic periodic_w;
	assign run_w = ctl_s2_r[`LT_CFG_RUN];
	assign wide_w = ctl_s2_r[`LT_CFG_WIDE];
	assign up_w = ctl_s2_r[`LT_CFG_UP] | wide_w;
	assign periodic_w = ctl_s2_r[`LT_CFG_PERIODIC];

	// ==========================================
	// prescaler
	logic [14:0] pre_r;
	logic [14:0] pre_last_w;
	logic tick_w;

	// unlisted codes divide by one, the safest reading
	always_comb begin
		unique case (ctl_s2_r[`LT_CFG_PRE_HI:`LT_CFG_PRE_LO])
			`LT_PRE_DIV16: pre_last_w = `LT_PRE_LAST16;
			`LT_PRE_DIV256: pre_last_w = `LT_PRE_LAST256;
			`LT_PRE_DIV32768: pre_last_w = `LT_PRE_LAST32768;
			default: pre_last_w = 15'h0000;
		endcase
	end

	assign tick_w = run_w & src_edge_w & (pre_r >= pre_last_w);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_r <= 15'h0000;
		end else if (!run_w) begin
			pre_r <= 15'h0000;
		end else if (src_edge_w) begin
			pre_r <= tick_w ? 15'h0000 : pre_r + 15'h0001;
		end
	end

	// ==========================================
	// counter
	logic run_d_r;
	logic start_w;
	logic hit_end_w;

	assign start_w = run_w & ~run_d_r;
	// full scale going up, zero going down, 16-bit mode only
	assign hit_end_w = ~wide_w & (up_w ? (cnt_r[15:0] == 16'hFFFF) : (cnt_r[15:0] == 16'h0000));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_d_r <= 1'b0;
		end else begin
			run_d_r <= run_w;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= `LT_RST_CNT;
		end else if (start_w) begin
			// wide mode starts from zero, narrow from the reload value
			cnt_r <= wide_w ? `LT_RST_CNT : {32'h00000000, ld_s2_r};
		end else if (tick_w) begin
			if (wide_w) begin
				cnt_r <= cnt_r + 48'h000000000001;
			end else if (hit_end_w && periodic_w) begin
				cnt_r <= {32'h00000000, ld_s2_r};
			end else if (up_w) begin
				// free-running wraps naturally at 16 bits
				cnt_r <= {32'h00000000, cnt_r[15:0] + 16'h0001};
			end else begin
				cnt_r <= {32'h00000000, cnt_r[15:0] - 16'h0001};
			end
		end
	end

	// ==========================================
	// interrupt
	logic ack_w;
	assign ack_w = wr_w && apb_req.paddr == `LT_OFS_IRQACK && !config_r[`LT_CFG_WIDE];

	// a new terminal count wins over an acknowledge in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else if (tick_w && hit_end_w) begin
			irq_r <= 1'b1;
		end else if (ack_w) begin
			irq_r <= 1'b0;
		end
	end

	assign irq_out = irq_r;

	// ==========================================
	// event capture
	logic [4:0] evt_num_w;
	logic evt_w;
	logic evt_d_r;
	logic cap_w;

	// event lines are same-clock logic, so no synchroniser
	assign evt_num_w = config_r[`LT_CFG_EVT_HI:`LT_CFG_EVT_LO];
	assign evt_w = (evt_num_w <= `LT_EVT_MAX) ? irq_events[evt_num_w] : 1'b0;
	assign cap_w = config_r[`LT_CFG_CAP_EN] & ~config_r[`LT_CFG_WIDE] & evt_w & ~evt_d_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_d_r <= 1'b0;
		end else begin
			evt_d_r <= evt_w;
		end
	end

	// only the rising edge captures; the counter is not disturbed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snap_r <= `LT_RST_SNAP;
		end else if (cap_w) begin
			snap_r <= cnt_r[15:0];
		end
	end

endmodule // lt_timer

// ==== testbench/lt_timer_checker.sv ====
// port assertions of the lifetime timer
`timescale 1ns/1ns
`include "lt_cfg.svh"
module lt_timer_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire lt_pkg::lt_apb_req_t apb_req,
	input wire lt_pkg::lt_apb_rsp_t apb_rsp,
	input wire logic lposc_clk,
	input wire logic xtal_clk,
	input wire logic precosc_clk,
	input wire logic [`LT_NUM_EVT-1:0] irq_events,
	input wire logic irq_out
);
	import lt_pkg::*;
	logic rd, wr, ack;
	logic [31:0] a, cfg_r, ld_r;
	// ====================
	// access decode
	assign a = apb_req.paddr;
	assign rd = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
	assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign ack = wr & (a == `LT_OFS_IRQACK);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// shadow of writes; only the bus side is visible
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= 32'h00000000;
			ld_r <= 32'h00000000;
		end else if (wr && a == `LT_OFS_CONFIG) begin
			cfg_r <= apb_req.pwdata & `LT_CFG_WMASK;
		end else if (wr && a == `LT_OFS_RELOAD) begin
			ld_r <= {16'h0000, apb_req.pwdata[15:0]};
		end
	end
	cfg_read_a: assert property (rd && a == `LT_OFS_CONFIG |-> apb_rsp.prdata == cfg_r)
		else $error("bad config read");
	reload_read_a: assert property (rd && a == `LT_OFS_RELOAD |-> apb_rsp.prdata == ld_r)
		else $error("bad reload read");
	snap_width_a: assert property (rd && a == `LT_OFS_SNAP |-> apb_rsp.prdata[31:16] == 16'h0000)
		else $error("snapshot too wide");
	low_half_a: assert property (rd && a == `LT_OFS_CNT_LO |-> apb_rsp.prdata[31:16] == 16'h0000)
		else $error("low half too wide");
	high_narrow_a: assert property (rd && a == `LT_OFS_CNT_HI && !cfg_r[4] && $past(!cfg_r[4], 8)
		|-> apb_rsp.prdata == 32'h00000000)
		else $error("high word set in narrow mode");
	irq_hold_a: assert property (irq_out && !ack |=> irq_out)
		else $error("interrupt dropped");
	irq_clear_a: assert property (ack && !cfg_r[`LT_CFG_WIDE] |=> !irq_out)
		else $error("interrupt not cleared");
	wide_quiet_a: assert property ($rose(irq_out) |-> !cfg_r[`LT_CFG_WIDE])
		else $error("interrupt in wide mode");
	cover property ($rose(irq_out));
	cover property (ack && irq_out);
	cover property (rd && a == `LT_OFS_SNAP && apb_rsp.prdata != 32'h00000000);
endmodule // lt_timer_checker
bind lt_timer lt_timer_checker u_lt_timer_checker (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .lposc_clk(lposc_clk), .xtal_clk(xtal_clk), .precosc_clk(precosc_clk),
	.irq_events(irq_events), .irq_out(irq_out));

// ==== testbench/lt_timer_tb.sv ====
// bench of the lifetime timer
`timescale 1ns/1ns
`include "lt_cfg.svh"
module lt_timer_tb;
	import lt_pkg::*;
	lt_apb_req_t req;
	lt_apb_rsp_t rsp;
	logic pclk, presetn, lposc_clk, xtal_clk, precosc_clk, irq_out;
	logic [17:0] ev;
	logic [31:0] rd, v;
	logic er;
	logic [15:0] ld;
	logic [3:0] pt [5] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h0};
	int bad_count, checked, n, k, e, t0, tp, cyc, up, per;
	int seed = 32'h8D447495;
	lt_timer u_lt_timer (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .lposc_clk(lposc_clk),
		.xtal_clk(xtal_clk), .precosc_clk(precosc_clk), .irq_events(ev), .irq_out(irq_out));
	// ====================
	// clocks: core and three unrelated 32 kHz sources
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always #15259 lposc_clk = ~lposc_clk;
	always #15263 xtal_clk = ~xtal_clk;
	always #15241 precosc_clk = ~precosc_clk;
	always @(posedge pclk) cyc <= cyc + 1;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// bounded waits: apb transfer and interrupt
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (rsp.pready === 1'b1) break;
		end
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
		if (n == 20) begin
			bad_count++;
			conclude();
		end
		#1;
	endtask
	task automatic wirq(input int lim);
		for (n = 0; n < lim; n++) begin
			@(posedge pclk);
			if (irq_out === 1'b1) break;
		end
		t0 = cyc;
		if (n == lim) begin
			bad_count++;
			conclude();
		end
		#1;
	endtask
	task automatic pulse(input int i);
		@(posedge pclk);
		ev <= 18'h00001 << i;
		@(posedge pclk);
		ev <= '0;
	endtask
	initial begin
		req = '0;
		ev = '0;
		presetn = 1'b0;
		{lposc_clk, xtal_clk, precosc_clk} = 3'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// reset values; count and snapshot ignore writes
		for (k = 0; k < 6; k++) begin
			if (k != 0 && k != 3) bus(1'b1, `LT_OFS_RELOAD + 4 * k, $random(seed));
			if (k != 4) bus(1'b0, `LT_OFS_RELOAD + 4 * k, 32'h0);
			if (k != 4) chk("reset or read-only", rd, 32'h0);
		end
		bus(1'b0, `LT_OFS_SNAP + 4, 32'h0);
		chk("unmapped", rd, 32'h0);
		chk("unmapped error", er, 1);
		v = $random(seed) & 32'hFFFFFF7F;
		bus(1'b1, `LT_OFS_CONFIG, v);
		bus(1'b0, `LT_OFS_CONFIG, 32'h0);
		chk("config", rd, v & `LT_CFG_WMASK);
		chk("config error", er, 0);
		// direction, mode and prescaler per table row
		for (k = 0; k < 5; k++) begin
			up = k % 2;
			per = k > 1;
			ld = up ? 16'hFFF0 : 16'h000F;
			bus(1'b1, `LT_OFS_CONFIG, 32'h0);
			bus(1'b1, `LT_OFS_IRQACK, 32'h0);
			bus(1'b1, `LT_OFS_RELOAD, ld);
			bus(1'b1, `LT_OFS_CONFIG, 32'h80 | per << 6 | up << 8 | pt[k]);
			wirq(9000);
			tp = t0;
			chk("irq held", irq_out, 1);
			if (pt[k] != 4'h0) bus(1'b0, `LT_OFS_CNT_LO, 32'h0);
			if (pt[k] != 4'h0) chk("count at irq", rd, per ? ld : (up ? 0 : 16'hFFFF));
			bus(1'b1, `LT_OFS_IRQACK, $random(seed));
			chk("irq acked", irq_out, 0);
			if (per) wirq(9000);
			if (per) chk("period", t0 - tp, 16 * (pt[k] == 4'h4 ? 16 : 1));
		end
		// capture off, wrong event, then the chosen one
		ld = $random(seed) | 16'h0001;
		e = {$random(seed)} % 18;
		bus(1'b1, `LT_OFS_CONFIG, 32'h0);
		bus(1'b1, `LT_OFS_RELOAD, ld);
		for (k = 0; k < 3; k++) begin
			bus(1'b1, `LT_OFS_CONFIG, 32'h8F | (k > 0 ? 32'h20000 : 0) | (k == 1 ? (e + 1) % 18 : e) << 12);
			pulse(e);
			bus(1'b0, `LT_OFS_SNAP, 32'h0);
			chk("snapshot", rd, k == 2 ? ld : 0);
		end
		// wide mode counts up by one per cycle, no capture
		bus(1'b1, `LT_OFS_CONFIG, 32'h0);
		bus(1'b1, `LT_OFS_CONFIG, 32'h20090 | e << 12);
		pulse(e);
		bus(1'b0, `LT_OFS_SNAP, 32'h0);
		chk("wide snapshot", rd, ld);
		bus(1'b0, `LT_OFS_CNT_LO, 32'h0);
		v = rd;
		bus(1'b0, `LT_OFS_CNT_LO, 32'h0);
		chk("wide step", rd - v, 3);
		bus(1'b0, `LT_OFS_CNT_HI, 32'h0);
		chk("wide high", rd, 32'h0);
		// slow sources, periodic down from one
		for (k = 1; k < 4; k++) begin
			bus(1'b1, `LT_OFS_CONFIG, 32'h0);
			bus(1'b1, `LT_OFS_IRQACK, 32'h0);
			bus(1'b1, `LT_OFS_RELOAD, 32'h1);
			bus(1'b1, `LT_OFS_CONFIG, 32'hC0 | k << 9);
			wirq(30000);
			bus(1'b0, `LT_OFS_CNT_LO, 32'h0);
			chk("slow count", rd, 32'h1);
		end
		conclude();
	end
endmodule // lt_timer_tb
